// >>> core/pdsc_top.sv
// Standby power-domain controller: domain gating, RAM bias, NVM and regulator selection.
// Functional notes
// - Standby entry with no activity retains all three switchable domains.
// - Leaving standby returns every switchable domain to active.
// - A running peripheral keeps its domain and all lower domains active.
// - An active domain may wake a retained higher domain, later retired again.
// - NVM is low power whenever the highest domain is retained.
// - In standby or idle, NVM is low power when unaccessed, per sleep-power field.
// - Software force field overrides automatic retention; forced states are honoured.
// - A linked higher domain stays active while its lower partner is active.
// - With dynamic gating and linking, middle domain tracks the lowest domain.
// - By default a RAM is back-biased in standby when its domain is retained.
// - Bias field: 0 bias-if-retained, 1 bias-in-standby, 2 off-in-standby, 3 off-if-retained.
// - Standby DMA access needs its RAM domain active and bias field zero.
// - Standby with all domains retained uses the low-power regulator.
// - Standby background tasks on generic or bus clocks use the main regulator.
// - Regulator field with a domain active: 0 automatic, 1 main, 2 low power.
// - Slow 32 kHz oscillator activity alone is not background activity.
// - Background tasks use the active-mode performance level and regulator type.
// - After a background task the chip wakes on interrupt or stays in standby.
// - Wake restores middle domain before highest, before the processor runs.
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module pdsc_top (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire logic [pdsc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [pdsc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [pdsc_pkg::DATA_W-1:0] reg_rdata,
    // Sleep control
    input wire logic standby_request,
    input wire logic idle_sleep,
    input wire logic wake_request,
    output logic cpu_run,
    // Domain activity requests
    input wire logic [pdsc_pkg::NUM_DOM-1:0] run_in_standby,
    input wire logic [pdsc_pkg::NUM_DOM-1:0] background_active,
    input wire logic [pdsc_pkg::NUM_DOM-1:0] dynamic_request,
    input wire logic bg_fast_clock,
    output logic [pdsc_pkg::NUM_DOM-1:0] domain_retained,
    // Memories
    input wire logic nvm_access,
    output logic nvm_low_power,
    output logic [pdsc_pkg::NUM_RAM-1:0] ram_back_bias,
    output logic [pdsc_pkg::NUM_RAM-1:0] ram_off,
    // DMA engine access, index 0 low-power SRAM, index 1 main SRAM
    input wire logic [pdsc_pkg::NUM_RAM-1:0] dma_request,
    output logic [pdsc_pkg::NUM_RAM-1:0] dma_grant,
    // Regulator and performance level
    input wire logic [pdsc_pkg::PERF_W-1:0] active_perf_level,
    input wire logic active_reg_switching,
    output logic use_lp_regulator,
    output logic [pdsc_pkg::PERF_W-1:0] sleepwalk_perf_level,
    output logic sleepwalk_reg_switching
);

    logic [1:0] rst_sync;
    logic rst_n;
    pdsc_pkg::pdsc_cfg_t cfg;
    pdsc_pkg::pdsc_state_t state;
    pdsc_pkg::pdsc_state_t next_state;
    pdsc_pkg::pdsc_status_t status;
    logic [pdsc_pkg::NUM_DOM-1:0] next_retained;
    logic [pdsc_pkg::NUM_DOM-1:0] static_need;
    logic [pdsc_pkg::NUM_DOM-1:0] dynamic_need;
    logic [pdsc_pkg::NUM_DOM-1:0] forced_need;
    logic [pdsc_pkg::NUM_DOM-1:0] need;
    logic [pdsc_pkg::NUM_DOM-1:0] target_retained;
    logic in_standby;
    logic sleeping;
    logic next_lp_regulator;
    logic next_nvm_low_power;
    logic [1:0] ram_bias_sel [pdsc_pkg::NUM_RAM];
    logic [pdsc_pkg::NUM_RAM-1:0] ram_domain_retained;
    logic [pdsc_pkg::NUM_RAM-1:0] next_ram_back_bias;
    logic [pdsc_pkg::NUM_RAM-1:0] next_ram_off;

    // The external reset is released through two flops so that the release is synchronous.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_sync <= 2'b00;
        end
        else
        begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    assign rst_n = rst_sync[1];

    assign in_standby = (state == pdsc_pkg::PDSC_STANDBY);
    assign sleeping = in_standby || ((state == pdsc_pkg::PDSC_RUN) && idle_sleep);

    // Standby configuration register.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg <= pdsc_pkg::CFG_RESET;
        end
        else if (reg_write && (reg_addr == pdsc_pkg::CFG_OFFSET))
        begin
            cfg <= reg_wdata[pdsc_pkg::CFG_W-1:0];
        end
    end

    assign status.state = state;
    assign status.nvm_low_power = nvm_low_power;
    assign status.regulator_low_power = use_lp_regulator;
    assign status.retained = domain_retained;

    // Read data stand only in the cycle after the read strobe; unmapped reads return zero.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata <= '0;
        end
        else if (reg_read && (reg_addr == pdsc_pkg::CFG_OFFSET))
        begin
            reg_rdata <= {{(pdsc_pkg::DATA_W-pdsc_pkg::CFG_W){1'b0}}, cfg};
        end
        else if (reg_read && (reg_addr == pdsc_pkg::STATUS_OFFSET))
        begin
            reg_rdata <= {{(pdsc_pkg::DATA_W-pdsc_pkg::STATUS_W){1'b0}}, status};
        end
        else
        begin
            reg_rdata <= '0;
        end
    end

    // Work out which domains must stay active in standby.
    always_comb
    begin
        static_need = '0;
        dynamic_need = '0;
        forced_need = '0;
        need = '0;
        static_need[2] = run_in_standby[2] | background_active[2];
        static_need[1] = run_in_standby[1] | background_active[1] | static_need[2];
        static_need[0] = run_in_standby[0] | background_active[0] | static_need[1];
        dynamic_need[1] = dynamic_request[1] & static_need[0];
        dynamic_need[2] = dynamic_request[2] & (static_need[0] | static_need[1]);
        forced_need[0] = (cfg.domain_force_config != pdsc_pkg::FORCE_AUTO);
        forced_need[1] = (cfg.domain_force_config == pdsc_pkg::FORCE_LOW_MID)
            || (cfg.domain_force_config == pdsc_pkg::FORCE_ALL);
        forced_need[2] = (cfg.domain_force_config == pdsc_pkg::FORCE_ALL);
        need = static_need | dynamic_need | forced_need;
        need[1] = need[1] | (need[0] & cfg.domain_link_select[pdsc_pkg::LINK_MID_BIT]);
        need[2] = need[2] | (need[1] & cfg.domain_link_select[pdsc_pkg::LINK_TOP_BIT]);
        need[1] = need[1] | need[2];
        need[0] = need[0] | need[1];
    end

    assign target_retained = in_standby ? ~need : '0;

    // One domain moves per cycle. Activation picks the lowest domain and retirement the highest,
    // so with a monotone target no lower domain is ever retained under an active higher one.
    always_comb
    begin
        logic done;
        done = 1'b0;
        next_retained = domain_retained;
        for (int i = 0; i < pdsc_pkg::NUM_DOM; i++)
        begin
            if (!done && domain_retained[i] && !target_retained[i])
            begin
                next_retained[i] = 1'b0;
                done = 1'b1;
            end
        end
        for (int i = pdsc_pkg::NUM_DOM - 1; i >= 0; i--)
        begin
            if (!done && !domain_retained[i] && target_retained[i])
            begin
                next_retained[i] = 1'b1;
                done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            domain_retained <= '0;
        end
        else
        begin
            domain_retained <= next_retained;
        end
    end

    // Sleep state sequencing.
    always_comb
    begin
        next_state = state;
        unique case (state)
            pdsc_pkg::PDSC_RUN:
            begin
                if (standby_request)
                begin
                    next_state = pdsc_pkg::PDSC_STANDBY;
                end
            end
            pdsc_pkg::PDSC_STANDBY:
            begin
                if (wake_request)
                begin
                    next_state = pdsc_pkg::PDSC_WAKE;
                end
            end
            pdsc_pkg::PDSC_WAKE:
            begin
                if (domain_retained == '0)
                begin
                    next_state = pdsc_pkg::PDSC_RUN;
                end
            end
            default:
            begin
                next_state = pdsc_pkg::PDSC_WAKE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= pdsc_pkg::PDSC_RUN;
        end
        else
        begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cpu_run <= 1'b1;
        end
        else
        begin
            cpu_run <= (next_state == pdsc_pkg::PDSC_RUN);
        end
    end

    // Regulator choice. The caller raises bg_fast_clock only for generic or bus clock activity.
    always_comb
    begin
        next_lp_regulator = 1'b0;
        if (!in_standby)
        begin
            next_lp_regulator = 1'b0;
        end
        else if (&domain_retained)
        begin
            next_lp_regulator = 1'b1;
        end
        else
        begin
            case (cfg.regulator_standby_select)
                pdsc_pkg::REG_PERFORMANCE: next_lp_regulator = 1'b0;
                pdsc_pkg::REG_LOW_POWER: next_lp_regulator = 1'b1;
                default: next_lp_regulator = !bg_fast_clock;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            use_lp_regulator <= 1'b0;
        end
        else
        begin
            use_lp_regulator <= next_lp_regulator;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sleepwalk_perf_level <= '0;
            sleepwalk_reg_switching <= 1'b0;
        end
        else
        begin
            sleepwalk_perf_level <= active_perf_level;
            sleepwalk_reg_switching <= active_reg_switching;
        end
    end

    assign next_nvm_low_power = next_retained[pdsc_pkg::NVM_DOM]
        || (sleeping && !nvm_access && (cfg.memory_sleep_power == pdsc_pkg::MSP_AUTO));

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            nvm_low_power <= 1'b0;
        end
        else
        begin
            nvm_low_power <= next_nvm_low_power;
        end
    end

    assign ram_bias_sel[pdsc_pkg::LP_RAM] = cfg.low_power_ram_bias;
    assign ram_bias_sel[pdsc_pkg::MAIN_RAM] = cfg.main_ram_bias;
    assign ram_domain_retained[pdsc_pkg::LP_RAM] = domain_retained[pdsc_pkg::LP_RAM_DOM];
    assign ram_domain_retained[pdsc_pkg::MAIN_RAM] = domain_retained[pdsc_pkg::MAIN_RAM_DOM];

    // Per-RAM bias, power and DMA access control.
    for (genvar j = 0; j < pdsc_pkg::NUM_RAM; j++)
    begin : g_ram
        always_comb
        begin
            next_ram_back_bias[j] = 1'b0;
            next_ram_off[j] = 1'b0;
            unique case (ram_bias_sel[j])
                pdsc_pkg::BIAS_RETAIN: next_ram_back_bias[j] = in_standby && ram_domain_retained[j];
                pdsc_pkg::BIAS_STANDBY: next_ram_back_bias[j] = in_standby;
                pdsc_pkg::BIAS_OFF_STANDBY: next_ram_off[j] = in_standby;
                pdsc_pkg::BIAS_OFF_RETAIN: next_ram_off[j] = in_standby && ram_domain_retained[j];
            endcase
        end

        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                ram_back_bias[j] <= 1'b0;
                ram_off[j] <= 1'b0;
            end
            else
            begin
                ram_back_bias[j] <= next_ram_back_bias[j];
                ram_off[j] <= next_ram_off[j];
            end
        end

        // A retained RAM domain never serves DMA, even in the wake sequence.
        // standby DMA gating
        assign dma_grant[j] = dma_request[j] && !ram_domain_retained[j]
            && (!in_standby || (ram_bias_sel[j] == pdsc_pkg::BIAS_RETAIN));
    end

endmodule

`default_nettype wire

// >>> common/pdsc_pkg.sv
// Constants, register map and types of the standby power-domain controller.
package pdsc_pkg;

    // Register bus geometry, and the domain, RAM and performance-level widths.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NUM_DOM = 3;
    localparam int NUM_RAM = 2;
    localparam int PERF_W = 2;

    // Register offsets (byte addresses).
    localparam logic [ADDR_W-1:0] CFG_OFFSET = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;

    // RAM indices, and domain indices of the RAMs and of the non-volatile memory.
    localparam int LP_RAM = 0;
    localparam int MAIN_RAM = 1;
    localparam int LP_RAM_DOM = 1;
    localparam int MAIN_RAM_DOM = 2;
    localparam int NVM_DOM = 2;
    localparam int TOP_DOM = 2;

    // Domain force configuration codes.
    localparam logic [1:0] FORCE_AUTO = 2'h0;
    localparam logic [1:0] FORCE_LOW = 2'h1;
    localparam logic [1:0] FORCE_LOW_MID = 2'h2;
    localparam logic [1:0] FORCE_ALL = 2'h3;

    // Domain link select bits: bit 0 ties middle to lowest, bit 1 ties highest to middle.
    localparam int LINK_MID_BIT = 0;
    localparam int LINK_TOP_BIT = 1;

    // RAM bias mode codes.
    localparam logic [1:0] BIAS_RETAIN = 2'h0;
    localparam logic [1:0] BIAS_STANDBY = 2'h1;
    localparam logic [1:0] BIAS_OFF_STANDBY = 2'h2;
    localparam logic [1:0] BIAS_OFF_RETAIN = 2'h3;

    // Regulator standby select codes.
    localparam logic [1:0] REG_AUTO = 2'h0;
    localparam logic [1:0] REG_PERFORMANCE = 2'h1;
    localparam logic [1:0] REG_LOW_POWER = 2'h2;

    // Memory sleep power codes.
    localparam logic [1:0] MSP_AUTO = 2'h0;

    // Standby configuration register contents.
    typedef struct packed {
        logic [1:0] memory_sleep_power;
        logic [1:0] regulator_standby_select;
        logic [1:0] main_ram_bias;
        logic [1:0] low_power_ram_bias;
        logic [1:0] domain_link_select;
        logic [1:0] domain_force_config;
    } pdsc_cfg_t;

    localparam int CFG_W = 12;
    localparam logic [CFG_W-1:0] CFG_RESET = 12'h000;

    // Controller state, one-hot.
    typedef enum logic [2:0] {
        PDSC_RUN = 3'b001,
        PDSC_STANDBY = 3'b010,
        PDSC_WAKE = 3'b100
    } pdsc_state_t;

    // Status register contents.
    typedef struct packed {
        logic [2:0] state;
        logic nvm_low_power;
        logic regulator_low_power;
        logic [NUM_DOM-1:0] retained;
    } pdsc_status_t;

    localparam int STATUS_W = 8;

endpackage

// >>> test/pdsc_checker.sv
// Concurrent assertions on the ports of the standby power-domain controller.
`timescale 1ns/1ps
`default_nettype none
module pdsc_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Observed ports
    input wire logic cpu_run,
    input wire logic [2:0] domain_retained,
    input wire logic nvm_low_power,
    input wire logic [1:0] ram_back_bias,
    input wire logic [1:0] ram_off,
    input wire logic [1:0] dma_request,
    input wire logic [1:0] dma_grant,
    input wire logic use_lp_regulator,
    input wire logic [1:0] active_perf_level,
    input wire logic [1:0] sleepwalk_perf_level
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    sequence all_retained;
        (domain_retained == 3'h7) [*2];
    endsequence
    sequence fully_active;
        domain_retained == 3'h0;
    endsequence
    a_fill_down: assert property (domain_retained inside {3'h0, 3'h4, 3'h6, 3'h7})
        else $error("lower domain retained below an active one");
    a_one_step: assert property (1'b1 |=> $countones(domain_retained ^ $past(domain_retained)) <= 1)
        else $error("more than one domain moved in one cycle");
    a_run_active: assert property (cpu_run |-> fully_active)
        else $error("processor runs with a domain retained");
    a_run_plain: assert property (cpu_run |-> !use_lp_regulator && ram_back_bias == 2'h0 && ram_off == 2'h0)
        else $error("low-power memory or regulator while running");
    a_wake_done: assert property ($rose(cpu_run) |-> $past(domain_retained) == 3'h0)
        else $error("processor started before all domains were active");
    a_nvm_top: assert property (domain_retained[2] |-> nvm_low_power)
        else $error("flash not low power with highest domain retained");
    a_lp_all: assert property (all_retained |-> use_lp_regulator)
        else $error("main regulator with all domains retained");
    a_dma_main: assert property (dma_grant[1] |-> dma_request[1] && !domain_retained[2])
        else $error("main memory granted while its domain is retained");
    a_dma_lp: assert property (dma_grant[0] |-> dma_request[0] && !domain_retained[1])
        else $error("low-power memory granted while its domain is retained");
    a_perf_copy: assert property (1'b1 |=> sleepwalk_perf_level == $past(active_perf_level))
        else $error("background performance level differs from active one");
endmodule
bind pdsc_top pdsc_checker chk (
    .clk(clk),
    .resetn(resetn),
    .cpu_run(cpu_run),
    .domain_retained(domain_retained),
    .nvm_low_power(nvm_low_power),
    .ram_back_bias(ram_back_bias),
    .ram_off(ram_off),
    .dma_request(dma_request),
    .dma_grant(dma_grant),
    .use_lp_regulator(use_lp_regulator),
    .active_perf_level(active_perf_level),
    .sleepwalk_perf_level(sleepwalk_perf_level)
);
`default_nettype wire

// >>> test/pdsc_activity_model.sv
// Behavioural model of the peripherals and DMA engine that ask for domain activity.
`timescale 1ns/1ps
`default_nettype none
module pdsc_activity_model (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Wanted activity
    input wire logic [2:0] want_run,
    input wire logic [2:0] want_bg,
    input wire logic [2:0] want_dyn,
    input wire logic want_fast,
    input wire logic [1:0] want_dma,
    input wire logic slow,
    // Requests toward the controller
    output logic [2:0] run_in_standby,
    output logic [2:0] background_active,
    output logic [2:0] dynamic_request,
    output logic bg_fast_clock,
    output logic [1:0] dma_request
);
    logic [11:0] stage;
    // fast clock only
    // Slow oscillator work is never reported as fast-clock activity.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            stage <= 12'h000;
            {dma_request, bg_fast_clock, dynamic_request, background_active, run_in_standby} <= 12'h000;
        end
        else
        begin
            stage <= {want_dma, want_fast, want_dyn, want_bg, want_run};
            // task ends later
            // A slow peripheral answers one cycle late, as a real one may.
            {dma_request, bg_fast_clock, dynamic_request, background_active, run_in_standby} <=
                slow ? stage : {want_dma, want_fast, want_dyn, want_bg, want_run};
        end
    end
endmodule
`default_nettype wire

// >>> test/pdsc_top_bench.sv
// Self-checking testbench for the standby power-domain controller.
`timescale 1ns/1ps
`default_nettype none
module pdsc_top_bench;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic standby_request = 1'b0;
    logic idle_sleep = 1'b0;
    logic wake_request = 1'b0;
    logic nvm_access = 1'b0;
    logic active_reg_switching = 1'b0;
    logic [1:0] active_perf_level = 2'h0;
    logic cpu_run, bg_fast_clock, nvm_low_power, use_lp_regulator, sleepwalk_reg_switching;
    logic [2:0] run_in_standby, background_active, dynamic_request, domain_retained;
    logic [1:0] ram_back_bias, ram_off, dma_request, dma_grant, sleepwalk_perf_level;
    logic [2:0] w_run = 3'h0;
    logic [2:0] w_bg = 3'h0;
    logic [2:0] w_dyn = 3'h0;
    logic w_fast = 1'b0;
    logic slow = 1'b0;
    logic [1:0] w_dma = 2'h0;
    logic [31:0] d;
    int failures = 0;
    int compares = 0;

    always #20 clk = ~clk;

    pdsc_top uut (.clk, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .standby_request,
        .idle_sleep, .wake_request, .cpu_run, .run_in_standby, .background_active, .dynamic_request,
        .bg_fast_clock, .domain_retained, .nvm_access, .nvm_low_power, .ram_back_bias, .ram_off, .dma_request,
        .dma_grant, .active_perf_level, .active_reg_switching, .use_lp_regulator, .sleepwalk_perf_level,
        .sleepwalk_reg_switching);
    pdsc_activity_model partner (.clk, .resetn, .want_run(w_run), .want_bg(w_bg), .want_dyn(w_dyn),
        .want_fast(w_fast), .want_dma(w_dma), .slow, .run_in_standby, .background_active, .dynamic_request,
        .bg_fast_clock, .dma_request);

    task automatic test_done();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        @(negedge clk);
        v = reg_rdata;
    endtask

    // Reference target: fill-down, dynamic, force, link, fill-down again; returns retained bits.
    function automatic logic [2:0] exp_ret(input logic [11:0] c, input logic [2:0] act, input logic [2:0] dyn);
        int a;
        a = act[2] ? 7 : act[1] ? 3 : act[0] ? 1 : 0;
        if (a % 2 == 1)
            a = a | (dyn & 6);
        a = a | (c[1:0] == 3 ? 7 : c[1:0] == 2 ? 3 : c[1:0]);
        if (c[2] && a % 2 == 1)
            a = a | 2;
        if (c[3] && (a / 2) % 2 == 1)
            a = a | 4;
        a = a >= 4 ? 7 : a >= 2 ? 3 : a;
        return 3'(~a);
    endfunction

    task automatic run_case(input logic [11:0] c, input logic [2:0] rs, bg, dyn, input logic fast,
        input logic [1:0] dma, input logic nacc);
        logic [2:0] er;
        logic f, en, eg;
        int lb, mb;
        wr(8'h00, {20'h0, c});
        f = fast & (c[9:8] != 2'h2);
        w_run <= rs;
        w_bg <= bg;
        w_dyn <= dyn;
        w_fast <= f;
        w_dma <= dma;
        nvm_access <= nacc;
        repeat (3) @(posedge clk);
        standby_request <= 1'b1;
        @(posedge clk);
        standby_request <= 1'b0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        er = exp_ret(c, rs | bg, dyn);
        lb = c[5:4];
        mb = c[7:6];
        en = er[2] | (c[11:10] == 2'h0 && !nacc);
        eg = er == 3'h7 || c[9:8] == 2'h2 || (c[9:8] != 2'h1 && !f);
        chk("retained", domain_retained, er);
        chk("nvm", nvm_low_power, en);
        chk("regulator", use_lp_regulator, eg);
        chk("bias", ram_back_bias, {mb == 1 || (mb == 0 && er[2]), lb == 1 || (lb == 0 && er[1])});
        chk("off", ram_off, {mb == 2 || (mb == 3 && er[2]), lb == 2 || (lb == 3 && er[1])});
        chk("dma", dma_grant, dma & ~er[2:1] & {mb == 0, lb == 0});
        rd(8'h04, d);
        chk("status", d, {24'h0, 3'b010, en, eg, er});
        @(posedge clk);
        if (dyn != 3'h0)
        begin
            w_dyn <= 3'h0;
            repeat (8) @(posedge clk);
            @(negedge clk);
            chk("dyn drop", domain_retained, exp_ret(c, rs | bg, 3'h0));
            @(posedge clk);
        end
        wake_request <= 1'b1;
        @(posedge clk);
        wake_request <= 1'b0;
        for (int i = 0; i < 12 && cpu_run !== 1'b1; i++)
            @(posedge clk);
        @(negedge clk);
        chk("wake", {cpu_run, domain_retained}, 4'h8);
    endtask

    initial
    begin
        repeat (40000) @(posedge clk);
        failures++;
        test_done();
    end

    initial
    begin
        void'($urandom(32'h47200530));
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        rd(8'h00, d);
        chk("cfg reset", d, 32'h0);
        rd(8'h04, d);
        chk("status reset", d, 32'h20);
        wr(8'h04, 32'hFF);
        rd(8'h04, d);
        chk("status ro", d, 32'h20);
        rd(8'h08, d);
        chk("unmapped", d, 32'h0);
        wr(8'h00, 32'hFFFFFFFF);
        rd(8'h00, d);
        chk("cfg rw", d, 32'hFFF);
        $display("test registers done");
        run_case(12'h000, 3'h0, 3'h0, 3'h0, 1'b0, 2'h3, 1'b0);
        for (int f = 1; f < 4; f++)
            run_case(12'(f), 3'h0, 3'h0, 3'h0, 1'b0, 2'h3, 1'b1);
        run_case(12'h004, 3'h1, 3'h0, 3'h0, 1'b1, 2'h3, 1'b0);
        run_case(12'h00C, 3'h0, 3'h1, 3'h0, 1'b1, 2'h3, 1'b0);
        run_case(12'h000, 3'h1, 3'h0, 3'h4, 1'b1, 2'h3, 1'b0);
        for (int b = 0; b < 4; b++)
            run_case(12'((b << 6) | (b << 4)), 3'h2, 3'h0, 3'h0, 1'b0, 2'h3, 1'b1);
        for (int r = 0; r < 4; r++)
            run_case(12'(r << 8), 3'h0, 3'h2, 3'h0, 1'b1, 2'h3, 1'b1);
        $display("test directed standby done");
        @(posedge clk);
        idle_sleep <= 1'b1;
        nvm_access <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("idle nvm", nvm_low_power, 1'b1);
        @(posedge clk);
        nvm_access <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("idle access", nvm_low_power, 1'b0);
        @(posedge clk);
        idle_sleep <= 1'b0;
        $display("test idle done");
        repeat (30)
        begin
            @(posedge clk);
            active_perf_level <= 2'($urandom);
            active_reg_switching <= 1'($urandom);
            slow <= 1'($urandom);
            run_case(12'($urandom), 3'($urandom), 3'($urandom), 3'($urandom), 1'($urandom), 2'($urandom),
                1'($urandom));
            chk("perf", {sleepwalk_reg_switching, sleepwalk_perf_level}, {active_reg_switching, active_perf_level});
        end
        $display("test random done");
        test_done();
    end
endmodule
`default_nettype wire
